// file: verilog/usatx_top.sv
`timescale 1ns/1ps
// Behaviour
// - enable hands data pin to transmitter output
// - sync mode times bits from transfer clock
// - data write fills buffer, starting transmission
// - buffer loads when idle or after stop
// - shifter sends frame at baud or clock
// - upper bits beyond character size ignored
// - buffer empty flag mirrors buffer state
// - empty interrupt held while flag set
// - data write clears buffer empty flag
// - complete flag sets when all sent
// - complete clears on service or one
// - complete interrupt requested when flag sets
// - parity inserted after data before stop
// - disable waits until buffer and shifter empty
// - disabled transmitter releases the data pin
// - start, data lsb first, parity, stop
// - parity is xor, inverted for odd
// - stop select picks one or two
// - polarity picks transfer clock change edge
module usatx_top
  import usatx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_global_irq_en,
  input wire logic i_tx_done_irq_ack,
  input wire logic i_transfer_clock_pin,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_buf_empty_irq,
  output logic o_tx_done_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  usatx_ctrl_t ctrl_r;
  usatx_state_t state_r;
  logic [11:0] baud_r;
  logic phase_r;
  logic [31:0] rdata_r;
  logic buf_full_r;
  logic [8:0] buf_data_r;
  logic [8:0] shift_r;
  logic [3:0] bit_idx_r;
  logic stop_idx_r;
  logic parity_r;
  logic txd_r;
  logic tx_done_r;
  logic [11:0] baud_cnt_r;
  logic [3:0] ovs_cnt_r;
  logic xck_s1_r;
  logic xck_s2_r;
  logic xck_s3_r;
  logic wr_fire;
  logic data_wr;
  logic stat_wr;
  logic ctrl_wr;
  logic baud_wr;
  logic [3:0] ovs_lim;
  logic async_tick;
  logic sync_tick;
  logic tick;
  logic frame_end;
  logic load_idle;
  logic load;
  logic shifter_busy;
  logic [8:0] wr_char;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_merged;
  logic [31:0] baud_merged;

  // merge a write word into an old word by byte lanes
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // ----------------------------------------------------------------
  // avalon slave, one wait state on every access
  // ----------------------------------------------------------------
  // the fixed wait state lets read data come from a flop at the
  // edge where waitrequest is low
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~phase_r;
  assign wr_fire = i_avs_write & phase_r;
  // byte lane 0 carries the character; other lanes are ignored
  assign data_wr = wr_fire & (i_avs_address == USATX_OFS_DATA) &
                   i_avs_byteenable[0] & ctrl_r.tx_enable;
  assign stat_wr = wr_fire & (i_avs_address == USATX_OFS_STATUS) &
                   i_avs_byteenable[0];
  assign ctrl_wr = wr_fire & (i_avs_address == USATX_OFS_CONTROL);
  assign baud_wr = wr_fire & (i_avs_address == USATX_OFS_BAUD);
  assign ctrl_merged = be_merge({19'h00000, ctrl_r}, i_avs_writedata,
                                i_avs_byteenable);
  assign baud_merged = be_merge({20'h00000, baud_r}, i_avs_writedata,
                                i_avs_byteenable);
  assign o_avs_readdata = rdata_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= (i_avs_read | i_avs_write) & ~phase_r;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (i_avs_address)
      USATX_OFS_STATUS: begin
        rd_mux[USATX_ST_BUF_EMPTY] = ~buf_full_r;
        rd_mux[USATX_ST_TX_DONE] = tx_done_r;
        rd_mux[USATX_ST_BUSY] = shifter_busy;
      end
      USATX_OFS_CONTROL: rd_mux = {19'h00000, ctrl_r};
      USATX_OFS_BAUD: rd_mux = {20'h00000, baud_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= 32'h00000000;
    end else if (i_avs_read & ~phase_r) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // format fields are used live; changing them mid-frame corrupts it
  // the divisor is picked up at an idle load or a divisor wrap
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= USATX_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= ctrl_merged[USATX_CTRL_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      baud_r <= USATX_BAUD_RST;
    end else if (baud_wr) begin
      baud_r <= baud_merged[USATX_BAUD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  assign ovs_lim = ctrl_r.double_speed_bit ? USATX_OVS_DOUBLE :
                   USATX_OVS_NORMAL;
  // async_tick marks the last clock of a bit period
  assign async_tick = (baud_cnt_r == 12'h000) & (ovs_cnt_r == 4'h0);

  // period is (divisor + 1) * (ovs_lim + 1) clocks
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      baud_cnt_r <= 12'h000;
      ovs_cnt_r <= 4'h0;
    end else if (load_idle) begin
      baud_cnt_r <= baud_r;
      ovs_cnt_r <= ovs_lim;
    end else if (baud_cnt_r == 12'h000) begin
      baud_cnt_r <= baud_r;
      ovs_cnt_r <= (ovs_cnt_r == 4'h0) ? ovs_lim : ovs_cnt_r - 4'h1;
    end else begin
      baud_cnt_r <= baud_cnt_r - 12'h001;
    end
  end

  // transfer clock comes from the far end; synchronise, then edge
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      xck_s1_r <= 1'b0;
      xck_s2_r <= 1'b0;
      xck_s3_r <= 1'b0;
    end else begin
      xck_s1_r <= i_transfer_clock_pin;
      xck_s2_r <= xck_s1_r;
      xck_s3_r <= xck_s2_r;
    end
  end

  // polarity zero changes data on the rising edge, one on the falling
  assign sync_tick = ctrl_r.sync_clock_polarity ?
                     (~xck_s2_r & xck_s3_r) :
                     (xck_s2_r & ~xck_s3_r);
  assign tick = ctrl_r.sync_mode ? sync_tick : async_tick;

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  assign wr_char = {ctrl_r.tx_ninth_bit, i_avs_writedata[7:0]} &
                   usatx_mask(ctrl_r.char_size);
  assign frame_end = tick & (state_r == USATX_STOP) &
                     ~(ctrl_r.stop_bit_select & ~stop_idx_r);
  // in sync mode an idle load waits for a change edge so the start
  // bit is a whole clock period long
  assign load_idle = buf_full_r & (state_r == USATX_IDLE) &
                     (~ctrl_r.sync_mode | sync_tick);
  assign load = load_idle | (buf_full_r & frame_end);

  // a write while full overwrites the waiting character; software
  // must poll the empty flag or use its interrupt
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      buf_full_r <= 1'b0;
      buf_data_r <= 9'h000;
    end else if (data_wr) begin
      buf_full_r <= 1'b1;
      buf_data_r <= wr_char;
    end else if (load) begin
      buf_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // txd_r is a flop so the pin never glitches between bits
  // the ninth bit rides in shift_r[8]; reserved sizes send eight bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= USATX_IDLE;
      shift_r <= 9'h000;
      bit_idx_r <= 4'h0;
      stop_idx_r <= 1'b0;
      parity_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (load) begin
      state_r <= USATX_START;
      shift_r <= buf_data_r;
      parity_r <= ^buf_data_r ^ ctrl_r.parity_mode[0];
      bit_idx_r <= 4'h0;
      stop_idx_r <= 1'b0;
      txd_r <= 1'b0;
    end else if (tick) begin
      case (state_r)
        USATX_START: begin
          state_r <= USATX_DATA;
          txd_r <= shift_r[0];
          shift_r <= {1'b0, shift_r[8:1]};
          bit_idx_r <= 4'h1;
        end
        USATX_DATA: begin
          if (bit_idx_r == usatx_nbits(ctrl_r.char_size)) begin
            if (ctrl_r.parity_mode[1]) begin
              state_r <= USATX_PARITY;
              txd_r <= parity_r;
            end else begin
              state_r <= USATX_STOP;
              txd_r <= 1'b1;
            end
          end else begin
            txd_r <= shift_r[0];
            shift_r <= {1'b0, shift_r[8:1]};
            bit_idx_r <= bit_idx_r + 4'h1;
          end
        end
        USATX_PARITY: begin
          state_r <= USATX_STOP;
          txd_r <= 1'b1;
        end
        USATX_STOP: begin
          if (ctrl_r.stop_bit_select & ~stop_idx_r) begin
            stop_idx_r <= 1'b1;
          end else begin
            state_r <= USATX_IDLE;
          end
          txd_r <= 1'b1;
        end
        default: begin
          state_r <= USATX_IDLE;
          txd_r <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit complete flag
  // ----------------------------------------------------------------
  // a frame ending in the clearing cycle still sets the flag
  // the ack pulse comes from the interrupt side when it is serviced
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_done_r <= 1'b0;
    end else if (frame_end & ~buf_full_r) begin
      tx_done_r <= 1'b1;
    end else if (i_tx_done_irq_ack |
                 (stat_wr & i_avs_writedata[USATX_ST_TX_DONE])) begin
      tx_done_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // busy covers start through last stop; a full buffer alone is not
  assign shifter_busy = (state_r != USATX_IDLE);
  // disabling only drops the pin once buffer and shifter are empty
  assign o_txd_oe = ctrl_r.tx_enable | buf_full_r |
                    shifter_busy;
  assign o_txd = txd_r;

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  // both are levels; the empty request repeats until served or masked
  assign o_buf_empty_irq = i_global_irq_en & ~buf_full_r &
                           ctrl_r.tx_buffer_empty_irq_en;
  assign o_tx_done_irq = i_global_irq_en & tx_done_r &
                         ctrl_r.tx_complete_irq_en;

endmodule : usatx_top

// file: verilog/usatx_pkg.sv
package usatx_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses of 32-bit words
  // ----------------------------------------------------------------
  localparam int USATX_AW = 4;
  localparam logic [3:0] USATX_OFS_DATA = 4'h0;
  localparam logic [3:0] USATX_OFS_STATUS = 4'h4;
  localparam logic [3:0] USATX_OFS_CONTROL = 4'h8;
  localparam logic [3:0] USATX_OFS_BAUD = 4'hc;

  // status bit positions
  localparam int USATX_ST_BUF_EMPTY = 0;
  localparam int USATX_ST_TX_DONE = 1;
  localparam int USATX_ST_BUSY = 2;

  // ----------------------------------------------------------------
  // control word, bit 0 is tx_enable
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] char_size;
    logic stop_bit_select;
    logic [1:0] parity_mode;
    logic sync_clock_polarity;
    logic sync_mode;
    logic double_speed_bit;
    logic tx_ninth_bit;
    logic tx_complete_irq_en;
    logic tx_buffer_empty_irq_en;
    logic tx_enable;
  } usatx_ctrl_t;

  localparam int USATX_CTRL_W = 13;
  localparam logic [12:0] USATX_CTRL_RST = 13'h0c00;
  localparam int USATX_BAUD_W = 12;
  localparam logic [11:0] USATX_BAUD_RST = 12'h000;

  // oversampling counts minus one per bit period
  localparam logic [3:0] USATX_OVS_NORMAL = 4'hf;
  localparam logic [3:0] USATX_OVS_DOUBLE = 4'h7;

  // character size codes
  localparam logic [2:0] USATX_SZ_5 = 3'h0;
  localparam logic [2:0] USATX_SZ_6 = 3'h1;
  localparam logic [2:0] USATX_SZ_7 = 3'h2;
  localparam logic [2:0] USATX_SZ_9 = 3'h7;

  // ----------------------------------------------------------------
  // frame states, gray along start-data-parity-stop
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    USATX_IDLE = 3'b000,
    USATX_START = 3'b001,
    USATX_DATA = 3'b011,
    USATX_PARITY = 3'b010,
    USATX_STOP = 3'b110
  } usatx_state_t;

  // number of data bits for a size code; reserved codes act as 8
  function automatic logic [3:0] usatx_nbits(input logic [2:0] sz);
    case (sz)
      USATX_SZ_5: usatx_nbits = 4'h5;
      USATX_SZ_6: usatx_nbits = 4'h6;
      USATX_SZ_7: usatx_nbits = 4'h7;
      USATX_SZ_9: usatx_nbits = 4'h9;
      default: usatx_nbits = 4'h8;
    endcase
  endfunction : usatx_nbits

  // mask that keeps only the bits a frame will send
  function automatic logic [8:0] usatx_mask(input logic [2:0] sz);
    case (sz)
      USATX_SZ_5: usatx_mask = 9'h01f;
      USATX_SZ_6: usatx_mask = 9'h03f;
      USATX_SZ_7: usatx_mask = 9'h07f;
      USATX_SZ_9: usatx_mask = 9'h1ff;
      default: usatx_mask = 9'h0ff;
    endcase
  endfunction : usatx_mask

endpackage : usatx_pkg

// file: dv/usatx_properties.sv
`timescale 1ns/1ps
module usatx_checker
  import usatx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_global_irq_en,
  input wire logic i_tx_done_irq_ack,
  input wire logic o_txd,
  input wire logic o_txd_oe,
  input wire logic o_buf_empty_irq,
  input wire logic o_tx_done_irq
);
  // ----------
  // shadow of the control word; full-word writes only
  // ----------
  logic [12:0] ctrl_r;
  wire land = i_avs_write && !o_avs_waitrequest;
  wire cwr = land && i_avs_address == USATX_OFS_CONTROL;
  wire dwr = land && i_avs_address == USATX_OFS_DATA && i_avs_byteenable[0];
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= USATX_CTRL_RST;
    end else if (cwr) begin
      ctrl_r <= i_avs_writedata[12:0];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  a_wait_one: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  a_idle_high: assert property (!o_txd_oe |-> o_txd)
    else $error("released line not high");
  a_irq_gated: assert property (
    !i_global_irq_en |-> !o_buf_empty_irq && !o_tx_done_irq)
    else $error("irq without global enable");
  // baud divisor stays 0 in the bench, so one bit is 16 clocks
  a_bit_length: assert property (
    $fell(o_txd) && !ctrl_r[5] && !ctrl_r[4] |-> !o_txd [*8] ##1 !o_txd [*8])
    else $error("zero bit too short");
  a_done_idle: assert property (
    $rose(o_tx_done_irq) && $past(i_global_irq_en) && $past(ctrl_r[2])
    && ctrl_r[1] |-> o_txd && o_buf_empty_irq)
    else $error("complete before line idle");
  a_ack_clears: assert property (
    i_tx_done_irq_ack && o_tx_done_irq |=> !o_tx_done_irq)
    else $error("complete not cleared");
  a_write_fills: assert property (
    dwr && ctrl_r[0] && i_global_irq_en && ctrl_r[1]
    |=> o_txd_oe && !o_buf_empty_irq)
    else $error("data write not buffered");
  a_oe_release: assert property (
    $fell(o_txd_oe) |-> o_txd && $past(o_txd) && !ctrl_r[0])
    else $error("pin released early");
  a_stay_off: assert property (
    !ctrl_r[0] && !o_txd_oe && !cwr |=> !o_txd_oe)
    else $error("disabled pin taken");
  c_release: cover property ($fell(o_txd_oe));
  c_done: cover property ($rose(o_tx_done_irq));
  c_fill: cover property (dwr ##1 !o_buf_empty_irq);
endmodule : usatx_checker

bind usatx_top usatx_checker u_chk (.*);

// file: dv/usatx_line_model.sv
`timescale 1ns/1ps
module usatx_line_model (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_line,
  input wire logic i_sync,
  input wire logic i_pol,
  input wire logic i_dbl,
  input wire logic [3:0] i_len,
  output logic o_xck,
  output logic [11:0] o_bits,
  output logic o_got
);
  // ----------
  // far receiver; its clock runs only while a sync transfer is armed
  // ----------
  logic [3:0] cnt_r;
  logic [3:0] n_r;
  logic busy_r;
  logic [1:0] dv_r;
  wire tick = i_sync ? (dv_r == 2'h3 && o_xck != i_pol) :
              i_dbl ? (cnt_r[2:0] == 3'h7) : (cnt_r == 4'hf);
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dv_r <= 2'h0;
      o_xck <= 1'b0;
    end else if (i_sync) begin
      dv_r <= dv_r + 2'h1;
      if (dv_r == 2'h3) begin
        o_xck <= !o_xck;
      end
    end else begin
      dv_r <= 2'h0;
      o_xck <= i_pol;
    end
  end
  // samples mid-bit, or on the edge opposite to the change edge
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 4'h0;
      n_r <= 4'h0;
      busy_r <= 1'b0;
      o_bits <= 12'h000;
      o_got <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      o_got <= 1'b0;
      if (!busy_r && !i_line && (!i_sync || tick)) begin
        busy_r <= 1'b1;
        cnt_r <= i_dbl ? 4'hc : 4'h8;
        n_r <= {3'h0, i_sync};
        o_bits <= 12'h000;
      end else if (busy_r && tick) begin
        o_bits[n_r] <= i_line;
        n_r <= n_r + 4'h1;
        if (n_r == i_len) begin
          busy_r <= 1'b0;
          o_got <= 1'b1;
        end
      end
    end
  end
endmodule : usatx_line_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  import usatx_pkg::*;
  // ----------
  // bench: Avalon master, pulled-up line, far receiver
  // ----------
  logic clk, rstn, rd, wr, gie, ack, sync_r, pol_r, dbl_r;
  logic [3:0] ad, len_r;
  logic [31:0] wd, rdata, q;
  logic waitr, transfer_clock_pin, txd, oe, eirq, dirq, got;
  logic [11:0] bits;
  int fails, total_checks;
  wire line = oe ? txd : 1'b1;
  usatx_top u_dut (.i_mclk(clk), .i_resetn(rstn), .i_avs_address(ad),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitr), .i_global_irq_en(gie),
    .i_tx_done_irq_ack(ack), .i_transfer_clock_pin(transfer_clock_pin), .o_txd(txd),
    .o_txd_oe(oe), .o_buf_empty_irq(eirq), .o_tx_done_irq(dirq));
  usatx_line_model u_far (.i_mclk(clk), .i_resetn(rstn), .i_line(line),
    .i_sync(sync_r), .i_pol(pol_r), .i_dbl(dbl_r), .i_len(len_r),
    .o_xck(transfer_clock_pin),
    .o_bits(bits), .o_got(got));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    total_checks++;
    if (v !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitr !== 1'b0 && k < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50) fails++;
  endtask : bus
  task automatic wait_got();
    int k;
    k = 0;
    while (got !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) fails++;
    @(posedge clk);
  endtask : wait_got
  function automatic logic [11:0] frm(input logic [8:0] d, input int nb,
      input logic pe, input logic od);
    logic [11:0] f;
    logic p;
    f = 12'hffe;
    p = od;
    for (int i = 0; i < nb; i++) begin
      f[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (pe) f[nb + 1] = p;
    return f;
  endfunction : frm
  task automatic t_regs();
    bus(1'b0, USATX_OFS_STATUS, 32'h0);
    chk("status", q, 32'h1);
    bus(1'b0, USATX_OFS_CONTROL, 32'h0);
    chk("control", q, 32'h0c00);
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, USATX_OFS_DATA, 32'h41);
    @(negedge clk);
    chk("pin", 32'(oe), 32'h0);
    bus(1'b1, USATX_OFS_BAUD, 32'h0);
  endtask : t_regs
  task automatic t_frame(input logic [12:0] c, input logic [7:0] d, input int nb);
    int len;
    logic [11:0] e;
    len = nb + c[8] + c[9] + 1;
    e = frm({c[3], d}, nb, c[8], c[7]) & ((12'h1 << (len + 1)) - 12'h1);
    len_r <= len[3:0];
    pol_r <= c[6];
    sync_r <= c[5];
    dbl_r <= c[4];
    bus(1'b1, USATX_OFS_CONTROL, {19'h0, c});
    bus(1'b1, USATX_OFS_DATA, {24'h0, d});
    wait_got();
    chk("frame", 32'(bits), 32'(e));
    repeat (16) @(posedge clk);
    sync_r <= 1'b0;
    dbl_r <= 1'b0;
  endtask : t_frame
  task automatic t_b2b();
    len_r <= 4'h9;
    bus(1'b1, USATX_OFS_STATUS, 32'h2);
    bus(1'b1, USATX_OFS_CONTROL, 32'hc07);
    bus(1'b1, USATX_OFS_DATA, 32'h55);
    bus(1'b1, USATX_OFS_DATA, 32'h3c);
    @(negedge clk);
    chk("empty irq", 32'(eirq), 32'h0);
    wait_got();
    chk("done early", 32'(dirq), 32'h0);
    repeat (10) @(negedge clk);
    chk("no gap", 32'(line), 32'h0);
    wait_got();
    chk("second", 32'(bits), 32'(frm(9'h3c, 8, 1'b0, 1'b0) & 12'h3ff));
    repeat (16) @(negedge clk);
    chk("done irq", 32'(dirq), 32'h1);
    chk("empty irq", 32'(eirq), 32'h1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(negedge clk);
    chk("ack", 32'(dirq), 32'h0);
    bus(1'b1, USATX_OFS_CONTROL, 32'hc05);
    @(negedge clk);
    chk("masked", 32'(eirq), 32'h0);
    bus(1'b1, USATX_OFS_DATA, 32'h0f);
    wait_got();
    repeat (16) @(posedge clk);
    bus(1'b0, USATX_OFS_STATUS, 32'h0);
    chk("complete", q, 32'h3);
    bus(1'b1, USATX_OFS_STATUS, 32'h2);
    bus(1'b0, USATX_OFS_STATUS, 32'h0);
    chk("w1c", q, 32'h1);
  endtask : t_b2b
  task automatic t_off();
    bus(1'b1, USATX_OFS_DATA, 32'h81);
    bus(1'b1, USATX_OFS_CONTROL, 32'hc00);
    @(negedge clk);
    chk("held", 32'(oe), 32'h1);
    wait_got();
    chk("last", 32'(bits), 32'(frm(9'h81, 8, 1'b0, 1'b0) & 12'h3ff));
    repeat (16) @(negedge clk);
    chk("released", 32'(oe), 32'h0);
  endtask : t_off
  initial begin
    rstn = 1'b0;
    {rd, wr, ack, sync_r, pol_r} = 5'h00;
    dbl_r = 1'b0;
    gie = 1'b1;
    ad = 4'h0;
    wd = 32'h0;
    len_r = 4'h9;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_frame(13'h0c01, 8'ha5, 8);
    t_frame(13'h0c11, 8'h5a, 8);
    t_frame(13'h0001, 8'he6, 5);
    t_frame(13'h0b01, 8'h4d, 7);
    t_frame(13'h1d89, 8'h3c, 9);
    t_frame(13'h0c21, 8'h96, 8);
    t_frame(13'h0461, 8'h2b, 6);
    t_b2b();
    t_off();
    conclude();
  end
  // a hang costs far less than this span of clocks
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : tb
